// >>> rtl/ecsr_pkg.sv
package ecsr_pkg;
	localparam int ECSR_AW = 4;
	localparam int ECSR_DW = 32;

	// word indices on the bus; byte address is four times the index
	localparam logic [3:0] ECSR_IDX_CANCEL_LO = 4'h4;
	localparam logic [3:0] ECSR_IDX_CANCEL_HI = 4'h5;
	localparam logic [3:0] ECSR_IDX_ERR_LO = 4'h6;
	localparam logic [3:0] ECSR_IDX_ERR_HI = 4'h7;
	localparam logic [3:0] ECSR_IDX_RAMP_LO = 4'h8;
	localparam logic [3:0] ECSR_IDX_RAMP_HI = 4'h9;
	localparam logic [3:0] ECSR_IDX_FLOOR_LO = 4'ha;
	localparam logic [3:0] ECSR_IDX_FLOOR_HI = 4'hb;
	localparam logic [3:0] ECSR_IDX_CTRL = 4'hc;

	// control register fields
	localparam int ECSR_CTRL_BYPASS = 0;
	localparam int ECSR_CTRL_CLR = 1;

	localparam logic [15:0] ECSR_CANCEL_RST = 16'h4800;
	localparam logic [7:0] ECSR_RAMP_LO_RST = 8'h04;
	localparam logic [7:0] ECSR_RAMP_HI_RST = 8'h00;
	localparam logic [15:0] ECSR_FLOOR_RST = 16'h0100;
	localparam logic [15:0] ECSR_FAST_THRESH = 16'h2000;
	localparam logic [15:0] ECSR_NOISE_RST = 16'h0000;
	localparam int ECSR_STEP_SHIFT = 4;

	typedef enum logic {ECSR_BUS_IDLE, ECSR_BUS_ACK} ecsr_bus_e;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} ecsr_sample_s;

	function automatic logic [15:0] ecsr_mag(input logic [15:0] x);
		ecsr_mag = x[15] ? 16'(~x + 16'h0001) : x;
	endfunction
endpackage

// >>> rtl/ecsr_level_track.sv
`timescale 1ns/1ns
`default_nettype none
module ecsr_level_track (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_clear,
	input wire logic [15:0] i_floor,
	input wire ecsr_pkg::ecsr_sample_s i_sample,
	output logic [15:0] o_level,
	output logic o_fast_adapt,
	output logic o_low_double_talk
);
	import ecsr_pkg::*;

	logic [15:0] next_level;
	logic next_fast;
	logic next_dt;
	logic [15:0] mag;
	logic [15:0] step;

	always_comb
	begin
		mag = ecsr_mag(i_sample.data);
		step = (o_level - mag) >> ECSR_STEP_SHIFT;
		if (step == 16'h0000)
			step = 16'h0001;
		next_level = o_level;
		if (i_clear)
			next_level = ECSR_CANCEL_RST;
		else
		begin
			if (i_sample.valid && (mag < o_level))
				next_level = o_level - step;
			if (next_level < i_floor)
				next_level = i_floor;
		end
		next_fast = o_level > ECSR_FAST_THRESH;
		next_dt = i_sample.valid && (mag > o_level);
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			o_level <= ECSR_CANCEL_RST;
			o_fast_adapt <= 1'b0;
			o_low_double_talk <= 1'b0;
		end
		else if (i_ce)
		begin
			o_level <= next_level;
			o_fast_adapt <= next_fast;
			o_low_double_talk <= next_dt;
		end
	end

	level_reset_a: assert property (@(posedge i_core_clk)
		$past(i_reset) |-> o_level == 16'h4800)
		else $error("level not at default after reset");
	level_clear_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset) i_ce && i_clear |=> o_level == 16'h4800)
		else $error("level not restored on clear");
	level_floor_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && !i_clear ##1 !$past(i_reset) |-> o_level >= $past(i_floor))
		else $error("level below floor");
	fast_select_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce ##1 i_ce |=> o_fast_adapt == ($past(o_level) > 16'h2000))
		else $error("speed select wrong");
endmodule
`default_nettype wire

// >>> rtl/ecsr_noise_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module ecsr_noise_ramp (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic [15:0] i_rate,
	input wire ecsr_pkg::ecsr_sample_s i_sample,
	output logic [15:0] o_noise
);
	import ecsr_pkg::*;

	logic [15:0] cnt;
	logic [15:0] target;
	logic [15:0] next_cnt;
	logic [15:0] next_target;
	logic [15:0] next_noise;

	always_comb
	begin
		next_target = i_sample.valid ? ecsr_mag(i_sample.data) : target;
		next_cnt = cnt + 16'h0001;
		next_noise = o_noise;
		if (cnt >= i_rate)
		begin
			next_cnt = 16'h0000;
			if (target > o_noise)
				next_noise = o_noise + 16'h0001;
			else if (target < o_noise)
				next_noise = o_noise - 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			cnt <= 16'h0000;
			target <= ECSR_NOISE_RST;
			o_noise <= ECSR_NOISE_RST;
		end
		else if (i_ce)
		begin
			cnt <= next_cnt;
			target <= next_target;
			o_noise <= next_noise;
		end
	end

	ramp_pace_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		!$stable(o_noise) && !$past(i_reset) |-> $past(cnt) >= $past(i_rate))
		else $error("noise stepped before rate period");
endmodule
`default_nettype wire

// >>> rtl/ecsr_top.sv
`timescale 1ns/1ns
`default_nettype none
module ecsr_top (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic [ecsr_pkg::ECSR_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [ecsr_pkg::ECSR_DW-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [ecsr_pkg::ECSR_DW-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire ecsr_pkg::ecsr_sample_s i_err_sample,
	input wire logic i_path_change,
	output logic [15:0] o_cancel_level,
	output logic [15:0] o_noise_level,
	output logic o_fast_adapt,
	output logic o_low_double_talk,
	output logic o_bypass
);
	import ecsr_pkg::*;

	ecsr_bus_e state;
	ecsr_bus_e next_state;
	logic next_wait;
	logic [ECSR_DW-1:0] next_rdata;

	logic [15:0] err;
	logic [15:0] ramp;
	logic [15:0] floor_lvl;
	logic soft_clr;
	logic [15:0] next_err;
	logic [15:0] next_ramp;
	logic [15:0] next_floor;
	logic next_bypass;
	logic next_soft_clr;
	logic wr_go;
	logic [7:0] wbyte;
	logic est_clear;
	logic [15:0] level;
	logic [15:0] noise;
	logic fast;
	logic low_dt;

	function automatic logic [7:0] read_byte(input logic [3:0] idx,
		input logic [15:0] lvl, input logic [15:0] e, input logic [15:0] r,
		input logic [15:0] f, input logic byp);
		case (idx)
			ECSR_IDX_CANCEL_LO: read_byte = lvl[7:0];
			ECSR_IDX_CANCEL_HI: read_byte = lvl[15:8];
			ECSR_IDX_ERR_LO: read_byte = e[7:0];
			ECSR_IDX_ERR_HI: read_byte = e[15:8];
			ECSR_IDX_RAMP_LO: read_byte = r[7:0];
			ECSR_IDX_RAMP_HI: read_byte = r[15:8];
			ECSR_IDX_FLOOR_LO: read_byte = f[7:0];
			ECSR_IDX_FLOOR_HI: read_byte = f[15:8];
			ECSR_IDX_CTRL: read_byte = {7'h00, byp};
			default: read_byte = 8'h00;
		endcase
	endfunction

	// bus handshake: request seen in IDLE, answered one cycle later in ACK
	always_comb
	begin
		next_state = state;
		next_rdata = o_avs_readdata;
		case (state)
			ECSR_BUS_IDLE:
			begin
				if (i_avs_read || i_avs_write)
					next_state = ECSR_BUS_ACK;
				if (i_avs_read)
					next_rdata = {24'h000000, read_byte(i_avs_address,
						level, err, ramp, floor_lvl, o_bypass)};
			end
			ECSR_BUS_ACK:
				next_state = ECSR_BUS_IDLE;
			default:
				next_state = ECSR_BUS_IDLE;
		endcase
		next_wait = next_state != ECSR_BUS_ACK;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			state <= ECSR_BUS_IDLE;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h00000000;
		end
		else if (i_ce)
		begin
			state <= next_state;
			o_avs_waitrequest <= next_wait;
			o_avs_readdata <= next_rdata;
		end
	end

	// writes commit at the edge where waitrequest is seen low
	assign wr_go = (state == ECSR_BUS_ACK) && i_avs_write &&
		i_avs_byteenable[0];
	assign wbyte = i_avs_writedata[7:0];

	always_comb
	begin
		next_err = err;
		next_ramp = ramp;
		next_floor = floor_lvl;
		next_bypass = o_bypass;
		// a clear request only lives for one cycle
		next_soft_clr = 1'b0;
		if (i_err_sample.valid)
			next_err = i_err_sample.data;
		if (wr_go)
		begin
			// status indices fall through, writes dropped
			case (i_avs_address)
				ECSR_IDX_RAMP_LO: next_ramp[7:0] = wbyte;
				ECSR_IDX_RAMP_HI: next_ramp[15:8] = wbyte;
				ECSR_IDX_FLOOR_LO: next_floor[7:0] = wbyte;
				ECSR_IDX_FLOOR_HI: next_floor[15:8] = wbyte;
				ECSR_IDX_CTRL:
				begin
					next_bypass = wbyte[ECSR_CTRL_BYPASS];
					next_soft_clr = wbyte[ECSR_CTRL_CLR];
				end
				default: next_ramp = ramp;
			endcase
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			err <= 16'h0000;
			ramp <= {ECSR_RAMP_HI_RST, ECSR_RAMP_LO_RST};
			floor_lvl <= ECSR_FLOOR_RST;
			o_bypass <= 1'b0;
			soft_clr <= 1'b0;
		end
		else if (i_ce)
		begin
			err <= next_err;
			ramp <= next_ramp;
			floor_lvl <= next_floor;
			o_bypass <= next_bypass;
			soft_clr <= next_soft_clr;
		end
	end

	assign est_clear = i_path_change || soft_clr || o_bypass;

	ecsr_level_track u_track (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_clear(est_clear),
		.i_floor(floor_lvl),
		.i_sample(i_err_sample),
		.o_level(level),
		.o_fast_adapt(fast),
		.o_low_double_talk(low_dt)
	);

	ecsr_noise_ramp u_noise (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_rate(ramp),
		.i_sample(i_err_sample),
		.o_noise(noise)
	);

	// outputs come straight from the submodule registers
	assign o_cancel_level = level;
	assign o_noise_level = noise;
	assign o_fast_adapt = fast;
	assign o_low_double_talk = low_dt;

	bus_answer_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && o_avs_waitrequest && (i_avs_read || i_avs_write)
		|=> !o_avs_waitrequest)
		else $error("bus request not answered in one cycle");
	err_capture_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && i_err_sample.valid |=> err == $past(i_err_sample.data))
		else $error("residual sample not captured");
	err_readonly_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		wr_go && i_ce && !i_err_sample.valid |=> $stable(err))
		else $error("residual changed by host write");
	ramp_default_a: assert property (@(posedge i_core_clk)
		$past(i_reset) |-> ramp == 16'h0004)
		else $error("ramp rate default wrong");
	ramp_hi_write_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		wr_go && i_ce && i_avs_address == 4'h9
		|=> ramp[15:8] == $past(i_avs_writedata[7:0]))
		else $error("ramp high byte write lost");
	ramp_lo_write_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		wr_go && i_ce && i_avs_address == ECSR_IDX_RAMP_LO
		|=> ramp[7:0] == $past(i_avs_writedata[7:0]))
		else $error("ramp low byte write lost");
	be_ignore_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_ACK && i_avs_write && !i_avs_byteenable[0]
		|=> $stable(ramp) && $stable(floor_lvl) && $stable(o_bypass))
		else $error("write without byte enable took effect");
	wait_pulse_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && !o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	rd_upper_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		o_avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	rd_level_lo_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_CANCEL_LO
		|=> o_avs_readdata == {24'h000000, $past(level[7:0])})
		else $error("level low byte read back wrong");
	rd_level_hi_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_CANCEL_HI
		|=> o_avs_readdata == {24'h000000, $past(level[15:8])})
		else $error("level high byte read back wrong");
	rd_err_lo_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_ERR_LO
		|=> o_avs_readdata == {24'h000000, $past(err[7:0])})
		else $error("residual low byte read back wrong");
	rd_err_hi_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_ERR_HI
		|=> o_avs_readdata == {24'h000000, $past(err[15:8])})
		else $error("residual high byte read back wrong");
	rd_ramp_lo_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_RAMP_LO
		|=> o_avs_readdata == {24'h000000, $past(ramp[7:0])})
		else $error("ramp low byte read back wrong");
	rd_ramp_hi_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_RAMP_HI
		|=> o_avs_readdata == {24'h000000, $past(ramp[15:8])})
		else $error("ramp high byte read back wrong");
	rd_floor_lo_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_FLOOR_LO
		|=> o_avs_readdata == {24'h000000, $past(floor_lvl[7:0])})
		else $error("floor low byte read back wrong");
	rd_floor_hi_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_FLOOR_HI
		|=> o_avs_readdata == {24'h000000, $past(floor_lvl[15:8])})
		else $error("floor high byte read back wrong");
	rd_ctrl_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		i_avs_address == ECSR_IDX_CTRL
		|=> o_avs_readdata == {24'h000000, 7'h00, $past(o_bypass)})
		else $error("control read back wrong");
	rd_unmapped_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && state == ECSR_BUS_IDLE && i_avs_read &&
		(i_avs_address < ECSR_IDX_CANCEL_LO || i_avs_address > ECSR_IDX_CTRL)
		|=> o_avs_readdata == 32'h00000000)
		else $error("unmapped index read not zero");
	bypass_hold_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && o_bypass |=> level == ECSR_CANCEL_RST)
		else $error("estimate not held at default in bypass");
	path_clear_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && i_path_change |=> level == ECSR_CANCEL_RST)
		else $error("estimate not restored on path change");
	soft_clear_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && soft_clr |=> level == ECSR_CANCEL_RST)
		else $error("estimate not restored on soft clear");
	soft_pulse_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		i_ce && soft_clr |=> !soft_clr)
		else $error("soft clear lasted more than one cycle");
	ce_freeze_a: assert property (@(posedge i_core_clk)
		disable iff (i_reset)
		!i_ce |=> $stable(ramp) && $stable(floor_lvl) && $stable(err) &&
		$stable(o_avs_readdata) && $stable(o_avs_waitrequest))
		else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// >>> bench/ecsr_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ecsr_top_bench;
	import ecsr_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_ce = 1'b1;
	logic [ECSR_AW-1:0] i_avs_address = '0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [ECSR_DW-1:0] i_avs_writedata = '0;
	logic [3:0] i_avs_byteenable = 4'hf;
	ecsr_sample_s i_err_sample = '0;
	logic i_path_change = 1'b0;
	logic [ECSR_DW-1:0] o_avs_readdata;
	logic o_avs_waitrequest, o_fast_adapt, o_low_double_talk, o_bypass;
	logic [15:0] o_cancel_level, o_noise_level;
	int err_total = 0;
	int samples_checked = 0;
	int seed = 32253;
	// behavioural model state
	int est = 'h4800;
	int flr = 'h0100;
	bit byp = 0;
	logic [15:0] held;

	ecsr_top DUT (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_err_sample(i_err_sample),
		.i_path_change(i_path_change),
		.o_cancel_level(o_cancel_level),
		.o_noise_level(o_noise_level),
		.o_fast_adapt(o_fast_adapt),
		.o_low_double_talk(o_low_double_talk),
		.o_bypass(o_bypass)
	);

	always #50 i_core_clk = ~i_core_clk;

	task automatic conclude();
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// entered just after a rising edge; leaves one edge after release
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic be, output logic [31:0] q);
		int n;
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, d};
		i_avs_byteenable <= {3'b000, be};
		n = 0;
		do
		begin
			@(posedge i_core_clk);
			n++;
		end
		while (o_avs_waitrequest !== 1'b0 && n < 20);
		if (o_avs_waitrequest !== 1'b0)
		begin
			err_total++;
			conclude();
		end
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 1'b1, q);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 1'b1, q);
		check(q, {24'h0, exp});
	endtask

	function automatic int mag(input logic [15:0] x);
		return x[15] ? 65536 - int'(x) : int'(x);
	endfunction

	task automatic send_sample(input logic [15:0] d);
		int m;
		int st;
		logic dt;
		logic dt_exp;
		m = mag(d);
		dt_exp = m > est;
		if (byp)
			est = 'h4800;
		else if (m < est)
		begin
			st = (est - m) >> 4;
			est -= (st < 1) ? 1 : st;
			if (est < flr)
				est = flr;
		end
		i_err_sample <= {1'b1, d};
		@(posedge i_core_clk);
		i_err_sample <= {1'b0, 16'h0000};
		dt = 1'b0;
		repeat (3)
		begin
			@(posedge i_core_clk);
			dt = dt | o_low_double_talk;
		end
		check(o_cancel_level, est[15:0]);
		check(dt, dt_exp);
		check(o_fast_adapt, est > 'h2000);
		rd_chk(4'h6, d[7:0]);
		rd_chk(4'h7, d[15:8]);
		rd_chk(4'h4, est[7:0]);
		rd_chk(4'h5, est[15:8]);
	endtask

	// change-to-change gap of the noise estimate is rate plus one
	task automatic ramp_period(input int r);
		logic [15:0] prev;
		int gap;
		wr(4'h8, r[7:0]);
		send_sample(16'h7000);
		prev = o_noise_level;
		gap = 0;
		while (o_noise_level === prev && gap < 40)
		begin
			@(posedge i_core_clk);
			gap++;
		end
		prev = o_noise_level;
		gap = 0;
		do
		begin
			@(posedge i_core_clk);
			gap++;
		end
		while (o_noise_level === prev && gap < 40);
		check(gap, r + 1);
	endtask

	initial
	begin
		repeat (20) @(posedge i_core_clk);
		i_reset <= 1'b0;
		@(posedge i_core_clk);
		rd_chk(4'h4, 8'h00);
		rd_chk(4'h5, 8'h48);
		rd_chk(4'h8, 8'h04);
		rd_chk(4'h9, 8'h00);
		rd_chk(4'hd, 8'h00);
		wr(4'h9, 8'h5a);
		wr(4'h8, 8'h3c);
		begin
			logic [31:0] q;
			bus(1'b1, 4'h8, 8'hff, 1'b0, q);
		end
		rd_chk(4'h8, 8'h3c);
		rd_chk(4'h9, 8'h5a);
		wr(4'h9, 8'h00);
		// status bytes must shrug off writes
		for (int a = 4; a < 8; a++)
			wr(a[3:0], 8'($random(seed)));
		wr(4'hd, 8'h77);
		rd_chk(4'h5, 8'h48);
		rd_chk(4'h6, 8'h00);
		rd_chk(4'hd, 8'h00);
		wr(4'ha, 8'h00);
		wr(4'hb, 8'h08);
		flr = 'h0800;
		for (int i = 0; i < 160; i++)
			send_sample(16'($random(seed)) & (i[0] ? 16'hffff : 16'h03ff));
		check(est, flr);
		check(o_cancel_level, flr);
		rd_chk(4'ha, 8'h00);
		rd_chk(4'hb, 8'h08);
		i_path_change <= 1'b1;
		@(posedge i_core_clk);
		i_path_change <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		est = 'h4800;
		check(o_cancel_level, 16'h4800);
		send_sample(16'h0010);
		wr(4'hc, 8'h01);
		byp = 1;
		est = 'h4800;
		repeat (2) @(posedge i_core_clk);
		check(o_bypass, 1'b1);
		send_sample(16'h0001);
		wr(4'hc, 8'h00);
		byp = 0;
		send_sample(16'h0020);
		wr(4'hc, 8'h02);
		est = 'h4800;
		repeat (2) @(posedge i_core_clk);
		check(o_cancel_level, 16'h4800);
		rd_chk(4'hc, 8'h00);
		ramp_period(0);
		ramp_period(4);
		ramp_period(9);
		// a low enable freezes every register, samples included
		i_ce <= 1'b0;
		i_err_sample <= {1'b1, 16'($random(seed))};
		@(posedge i_core_clk);
		held = o_noise_level;
		repeat (4) @(posedge i_core_clk);
		check(o_noise_level, held);
		check(o_cancel_level, est[15:0]);
		i_ce <= 1'b1;
		i_err_sample <= {1'b0, 16'h0000};
		@(posedge i_core_clk);
		rd_chk(4'h7, 8'h70);
		send_sample(16'h0040);
		// second reset in mid-run restores defaults
		i_reset <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		@(posedge i_core_clk);
		check(o_cancel_level, 16'h4800);
		rd_chk(4'h8, 8'h04);
		check(o_noise_level, 16'h0000);
		check(o_bypass, 1'b0);
		rd_chk(4'hb, 8'h01);
		conclude();
	end
endmodule
`default_nettype wire
